// [logic/dccx_ctrl.sv]
// Head-end channel change transaction controller
`timescale 1ns/1ps


module dccx_ctrl (
  // Clock and reset
  input  wire  logic                          CLK_SYS,
  input  wire  logic                          RESET,
  // Configuration and command
  input  wire  dccx_pkg::dccx_cfg_t           CFG,
  input  wire  dccx_pkg::dccx_cmd_t           CMD,
  // Service transaction status
  input  wire  logic                          SVC_CMD_OUT,   // own DSA/DSC command outstanding
  input  wire  logic                          SVC_ACK_WAIT,  // awaiting ack of modem request
  input  wire  logic                          SVC_REQ_IN,    // modem DSA/DSC request arrives
  input  wire  logic                          SVC_REQ_NEEDS, // that request needs a change
  input  wire  logic                          SVC_CMD_WANT,  // head-end wants a service command
  // Messages from modem
  input  wire  logic                          RSP_IN,        // change response received
  input  wire  logic                          ARRIVED,       // modem seen on new channel
  input  wire  logic                          LATE_RNG,      // ranging on a removed identifier
  // Outputs
  output logic                                REQ_SEND,      // send change request pulse
  output logic                                REJ_TEMP_DCC,  // reject-temporary-DCC pulse
  output logic                                REJ_TEMP,      // reject-temporary pulse
  output logic                                SVC_CMD_GO,    // grant own service command
  output logic                                BUSY,
  output logic                                FAIL,          // transaction failed pulse
  output logic                                OLD_HOLD,      // keep old-channel resources
  output logic                                NEW_HOLD,      // keep new-channel resources
  output logic                                RNG_ABORT,     // ranging abort pulse
  output logic                                REINIT_BLOCKED,// re-init request refused pulse
  output logic [dccx_pkg::MS_W-1:0]           T15_MS
);
  import dccx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dccx_state_t        st;
    logic [TICK_W-1:0]  tick;
    logic [MS_W-1:0]    t11_cnt;
    logic [MS_W-1:0]    t13_cnt;
    logic [MS_W-1:0]    t15_cnt;
    logic [RETRY_W-1:0] retries;
    logic               pend;       // change owed after a rejected modem request
    dccx_tech_t         tech;
    logic               landed;     // modem confirmed on new channel
    logic               req_send;
    logic               rej_dcc;
    logic               rej_tmp;
    logic               svc_go;
    logic               busy;
    logic               fail;
    logic               old_hold;
    logic               new_hold;
    logic               rng_abort;
    logic               reinit_blk;
    logic [MS_W-1:0]    t15;
  } dccx_regs_t;

  dccx_regs_t r;
  dccx_regs_t next_r;
  logic [MS_W-1:0] t15_calc;
  logic            ms;
  logic            start;
  logic            blocked;

  dccx_t15_calc u_t15 (
    .cfg        (CFG),
    .tech       (r.tech),
    .jump_valid (CMD.jump_valid),
    .jump_ms    (CMD.jump_ms),
    .t15_ms     (t15_calc)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.req_send   = 1'b0;
    next_r.rej_dcc    = 1'b0;
    next_r.rej_tmp    = 1'b0;
    next_r.svc_go     = 1'b0;
    next_r.fail       = 1'b0;
    next_r.rng_abort  = 1'b0;
    next_r.reinit_blk = 1'b0;
    // Millisecond tick keeps the timers narrow
    ms = (r.tick == TICK_W'(MS_TICK_CYCLES - 1));
    next_r.tick = ms ? '0 : r.tick + 1'b1;
    blocked = SVC_CMD_OUT || SVC_ACK_WAIT;
    start = 1'b0;
    // Resource hold timers count down in ms
    if (ms && r.t13_cnt != '0) begin
      next_r.t13_cnt = r.t13_cnt - 1'b1;
    end
    if (ms && r.t15_cnt != '0) begin
      next_r.t15_cnt = r.t15_cnt - 1'b1;
    end
    // Arrival is remembered until the next request, so a one-cycle pulse releases both holds
    next_r.landed   = r.landed || ARRIVED;
    next_r.old_hold = (next_r.t13_cnt != '0) && !next_r.landed;
    next_r.new_hold = (next_r.t15_cnt != '0) && !next_r.landed;
    if (LATE_RNG && r.t15_cnt == '0 && r.tech == DCCX_TECH_INIT_MAINT) begin
      next_r.rng_abort = 1'b1;
    end
    unique case (r.st)
      DCCX_IDLE: begin
        if (SVC_REQ_IN && SVC_REQ_NEEDS) begin
          next_r.rej_dcc = 1'b1;
          next_r.pend    = 1'b1;
        end
        if ((CMD.valid || r.pend) && !blocked) begin
          if (CMD.valid && CMD.tech == DCCX_TECH_REINIT && CFG.prov_fixes_chan) begin
            next_r.reinit_blk = 1'b1;
          end else begin
            start = 1'b1;
          end
        end else if (SVC_CMD_WANT && !CMD.valid && !r.pend) begin
          next_r.svc_go = 1'b1;
        end
        if (start) begin
          next_r.pend = 1'b0;
          next_r.tech = CMD.valid ? CMD.tech : DCCX_TECH_DIRECT;
          next_r.retries = '0;
          next_r.st      = DCCX_SEND;
          next_r.busy    = 1'b1;
        end
      end
      DCCX_SEND: begin
        next_r.req_send = 1'b1;
        next_r.t11_cnt  = CFG.t11;
        next_r.landed   = 1'b0;
        next_r.t13_cnt  = MS_W'(T13_MS);
        next_r.t15      = t15_calc;
        next_r.t15_cnt  = (r.tech == DCCX_TECH_REINIT) ? '0 : t15_calc;
        next_r.st       = DCCX_WAIT;
      end
      DCCX_WAIT: begin
        if (SVC_REQ_IN) begin
          next_r.rej_tmp = 1'b1;
        end
        if (RSP_IN || ARRIVED) begin
          next_r.t11_cnt = '0;
          next_r.st      = DCCX_HOLD;
        end else if (ms && r.t11_cnt != '0) begin
          next_r.t11_cnt = r.t11_cnt - 1'b1;
        end else if (r.t11_cnt == '0) begin
          if (r.retries < CFG.req_retries) begin
            next_r.retries = r.retries + 1'b1;
            next_r.st      = DCCX_SEND;
          end else begin
            next_r.fail = 1'b1;
            next_r.st   = DCCX_DONE;
          end
        end
      end
      DCCX_HOLD: begin
        if (SVC_REQ_IN) begin
          next_r.rej_tmp = 1'b1;
        end
        if (ARRIVED || r.tech == DCCX_TECH_REINIT || (r.t15_cnt == '0 && r.t13_cnt == '0)) begin
          next_r.st = DCCX_DONE;
        end
      end
      DCCX_DONE: begin
        next_r.busy = 1'b0;
        next_r.st   = DCCX_IDLE;
      end
      default: begin
        next_r.st = DCCX_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r      <= '0;
      r.tech <= DCCX_TECH_DIRECT;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign REQ_SEND       = r.req_send;
  assign REJ_TEMP_DCC   = r.rej_dcc;
  assign REJ_TEMP       = r.rej_tmp;
  assign SVC_CMD_GO     = r.svc_go;
  assign BUSY           = r.busy;
  assign FAIL           = r.fail;
  assign OLD_HOLD       = r.old_hold;
  assign NEW_HOLD       = r.new_hold;
  assign RNG_ABORT      = r.rng_abort;
  assign REINIT_BLOCKED = r.reinit_blk;
  assign T15_MS         = r.t15;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_NO_SVC_WHILE_BUSY: assert property (@(posedge CLK_SYS) disable iff (RESET)
    SVC_CMD_GO |-> !$past(r.busy)) else $error("service command granted during change");
  AST_NO_DCC_WHEN_BLOCKED: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (r.st == DCCX_IDLE && next_r.st == DCCX_SEND) |-> !blocked) else $error("change while blocked");
  AST_T15_BOUNDS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    t15_calc >= MS_W'(T15_MIN_MS) && t15_calc <= MS_W'(T15_MAX_MS)) else $error("T15 out of range");
  AST_INIT_T15: assert property (@(posedge CLK_SYS) disable iff (RESET)
    r.tech == DCCX_TECH_INIT_MAINT |-> t15_calc >= MS_W'(INIT_MAINT_RNG_MS)) else $error("initial term lost");
  AST_DEFAULT_JUMP: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (!CMD.jump_valid && r.tech == DCCX_TECH_DIRECT && CFG.ucd_period == '0 && CFG.sync_period == '0
     && CFG.rng_opp_period == '0 && CFG.rng_allow == MS_W'(RNG_ALLOW_MIN_MS))
    |-> t15_calc == MS_W'(T15_MIN_MS)) else $error("default jump wrong");
  AST_REJ_DCC: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (r.st == DCCX_IDLE && SVC_REQ_IN && SVC_REQ_NEEDS) |=> REJ_TEMP_DCC) else $error("missing reject");
  AST_CROSS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (r.st == DCCX_WAIT && SVC_REQ_IN) |=> REJ_TEMP) else $error("crossing not rejected");
  AST_SEND_AFTER_START: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (r.st == DCCX_SEND) |=> REQ_SEND && r.st == DCCX_WAIT) else $error("no send");
  AST_REINIT_REFUSED: assert property (@(posedge CLK_SYS) disable iff (RESET)
    REINIT_BLOCKED |-> $past(r.st) == DCCX_IDLE && $past(CFG.prov_fixes_chan)) else $error("bad refusal");
  AST_OLD_HOLD: assert property (@(posedge CLK_SYS) disable iff (RESET)
    REQ_SEND |=> OLD_HOLD || $past(ARRIVED)) else $error("old resources dropped");

  COV_FAIL:   cover property (@(posedge CLK_SYS) disable iff (RESET) FAIL);
  COV_RESEND: cover property (@(posedge CLK_SYS) disable iff (RESET) REQ_SEND && r.retries != '0);
  COV_ABORT:  cover property (@(posedge CLK_SYS) disable iff (RESET) RNG_ABORT);
  COV_DONE:   cover property (@(posedge CLK_SYS) disable iff (RESET) r.st == DCCX_HOLD && ARRIVED);

endmodule // dccx_ctrl

// [logic/dccx_pkg.sv]
// Package: constants, types and timing counts of the channel change transaction controller
package dccx_pkg;

  // ----------------------------------------------------------------
  // Timing base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned NS_PER_US     = 1000;
  // Timers tick in milliseconds; one tick is this many clocks
  localparam int unsigned MS_TICK_CYCLES = NS_PER_MS / CLK_PERIOD_NS;

  // Time values in milliseconds, as printed
  localparam int unsigned JUMP_DEFAULT_MS   = 1300;  // 1,3 s when the modem reports none
  localparam int unsigned INIT_MAINT_RNG_MS = 30000; // 30 s ranging term for initial maintenance
  localparam int unsigned RNG_ALLOW_MIN_MS  = 20;    // 20 ms least allowance
  localparam int unsigned RNG_ALLOW_MAX_MS  = 40;    // 40 ms most allowance
  localparam int unsigned T15_MAX_MS        = 35000; // 35 s ceiling
  localparam int unsigned T13_MS            = 1000;  // T13 is one second
  localparam int unsigned T15_MIN_MS        = 2 * T13_MS; // floor is twice T13

  // Default protocol times and retry limit (configurable through ports)
  localparam int unsigned T11_DEFAULT_MS     = 1000;
  localparam int unsigned DCC_REQ_RETRY_DFLT = 3;

  // ----------------------------------------------------------------
  // Widths and field layouts
  // ----------------------------------------------------------------
  localparam int unsigned MS_W    = 17;  // holds up to 131 s
  localparam int unsigned RETRY_W = 4;
  localparam int unsigned TICK_W  = 17;

  // Initialization technique codes carried in the change request
  typedef enum logic [2:0] {
    DCCX_TECH_REINIT     = 3'h0,
    DCCX_TECH_INIT_MAINT = 3'h1,
    DCCX_TECH_STA_MAINT  = 3'h2,
    DCCX_TECH_EITHER     = 3'h3,
    DCCX_TECH_DIRECT     = 3'h4
  } dccx_tech_t;

  // Configuration of the destination side, all times in ms
  typedef struct packed {
    logic [MS_W-1:0]    ucd_period;     // upstream descriptor send period
    logic [MS_W-1:0]    sync_period;    // sync message send period
    logic [MS_W-1:0]    rng_opp_period; // unicast ranging opportunity period
    logic [MS_W-1:0]    rng_allow;      // map and request allowance
    logic [MS_W-1:0]    t11;            // response wait
    logic [RETRY_W-1:0] req_retries;    // request retry limit
    logic               prov_fixes_chan;// provisioning names channel or frequency
  } dccx_cfg_t;

  // A channel change request from the scheduler
  typedef struct packed {
    logic             valid;
    dccx_tech_t       tech;
    logic             jump_valid;   // modem reported a jump duration
    logic [MS_W-1:0]  jump_ms;
  } dccx_cmd_t;

  // Transaction states, Gray coded from IDLE through DONE along the usual path
  typedef enum logic [2:0] {
    DCCX_IDLE    = 3'b000,
    DCCX_SEND    = 3'b001,
    DCCX_WAIT    = 3'b011,
    DCCX_HOLD    = 3'b010,
    DCCX_DONE    = 3'b110
  } dccx_state_t;

endpackage : dccx_pkg

// [logic/dccx_t15_calc.sv]
// T15 reservation timer calculator with clamping
`timescale 1ns/1ps

module dccx_t15_calc (
  // Inputs
  input  wire dccx_pkg::dccx_cfg_t                cfg,
  input  wire dccx_pkg::dccx_tech_t               tech,
  input  wire logic                               jump_valid,
  input  wire logic [dccx_pkg::MS_W-1:0]          jump_ms,
  // Result
  output logic      [dccx_pkg::MS_W-1:0]          t15_ms
);
  import dccx_pkg::*;

  logic [MS_W+2:0] modem_jump_duration;
  logic [MS_W+2:0] upstream_descriptor_acquire_time;
  logic [MS_W+2:0] downstream_sync_acquire_time;
  logic [MS_W+2:0] ranging_request_turnaround;
  logic [MS_W+2:0] rng_allow_clamped;
  logic [MS_W+2:0] sum;

  // Sum of four terms, then clamp
  always_comb begin
    modem_jump_duration = jump_valid ? {3'h0, jump_ms} : (MS_W+3)'(JUMP_DEFAULT_MS);
    upstream_descriptor_acquire_time = {3'h0, cfg.ucd_period} << 1;
    downstream_sync_acquire_time = {3'h0, cfg.sync_period} << 1;
    // Allowance is held inside the documented window
    rng_allow_clamped = {3'h0, cfg.rng_allow};
    if (rng_allow_clamped < (MS_W+3)'(RNG_ALLOW_MIN_MS)) begin
      rng_allow_clamped = (MS_W+3)'(RNG_ALLOW_MIN_MS);
    end else if (rng_allow_clamped > (MS_W+3)'(RNG_ALLOW_MAX_MS)) begin
      rng_allow_clamped = (MS_W+3)'(RNG_ALLOW_MAX_MS);
    end
    if (tech == DCCX_TECH_INIT_MAINT || tech == DCCX_TECH_EITHER) begin
      ranging_request_turnaround = (MS_W+3)'(INIT_MAINT_RNG_MS);
    end else begin
      ranging_request_turnaround = ({3'h0, cfg.rng_opp_period} << 1) + rng_allow_clamped;
    end
    sum = modem_jump_duration + upstream_descriptor_acquire_time
        + downstream_sync_acquire_time + ranging_request_turnaround;
    if (sum < (MS_W+3)'(T15_MIN_MS)) begin
      t15_ms = MS_W'(T15_MIN_MS);
    end else if (sum > (MS_W+3)'(T15_MAX_MS)) begin
      t15_ms = MS_W'(T15_MAX_MS);
    end else begin
      t15_ms = sum[MS_W-1:0];
    end
  end

endmodule // dccx_t15_calc

// [tb/dccx_modem_model.sv]
// Modem-side partner model that answers channel change requests
`timescale 1ns/1ps

module dccx_modem_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Head-end messages
  input  wire logic        req_send,
  input  wire logic        rej_temp_dcc,
  input  wire logic        rej_temp,
  // Bench control
  input  wire logic        slow,
  input  wire logic        ask,
  input  wire logic        ask_needs,
  // Modem messages
  output logic             rsp_in,
  output logic             arrived,
  output logic             svc_req_in,
  output logic             svc_req_needs,
  output logic [16:0]      jump_ms,
  output logic             retried
);
  import dccx_pkg::*;

  // ----------------------------------------------------------------
  // Jump report
  // ----------------------------------------------------------------
  localparam int unsigned RESYNC_MS = 150;
  localparam int unsigned CLEAN_MS  = 100;
  assign jump_ms = 17'(RESYNC_MS + CLEAN_MS + T11_DEFAULT_MS);

  // ----------------------------------------------------------------
  // Answer sequencing
  // ----------------------------------------------------------------
  int unsigned cnt;
  logic [1:0]  phase;     // 0 idle, 1 respond, 2 arrive, 3 retry
  logic        rej_seen;

  // Slow mode stretches both answers so the head-end sees a sluggish modem
  // modem yields, retries later
  always_ff @(posedge clk_sys) begin
    rsp_in     <= 1'b0;
    arrived    <= 1'b0;
    svc_req_in <= 1'b0;
    if (reset) begin
      phase         <= 2'h0;
      cnt           <= 0;
      rej_seen      <= 1'b0;
      retried       <= 1'b0;
      svc_req_needs <= 1'b0;
    end else begin
      if (rej_temp_dcc || rej_temp) begin
        rej_seen <= 1'b1;
      end
      if (ask) begin
        svc_req_in    <= 1'b1;
        svc_req_needs <= ask_needs;
      end
      // no redundant target
      // Targets always differ from the current channel, so no redundant reply
      // arrival always succeeds
      // The head-end confirms arrival itself, so no response resend or fallback
      if (req_send) begin
        phase <= 2'h1;
        cnt   <= slow ? 30 : 2;
      end else if (phase != 2'h0) begin
        if (cnt != 0) begin
          cnt <= cnt - 1;
        end else if (phase == 2'h1) begin
          rsp_in <= 1'b1;
          phase  <= 2'h2;
          cnt    <= slow ? 40 : 3;
        end else if (phase == 2'h2) begin
          arrived <= 1'b1;
          phase   <= rej_seen ? 2'h3 : 2'h0;
          cnt     <= 6;
        end else begin
          svc_req_in    <= 1'b1;
          svc_req_needs <= 1'b0;
          rej_seen      <= 1'b0;
          retried       <= 1'b1;
          phase         <= 2'h0;
        end
      end
    end
  end

endmodule // dccx_modem_model

// [tb/channel_change_transaction_ctrl_bench.sv]
// Self-checking bench for the channel change transaction controller
`timescale 1ns/1ps

module channel_change_transaction_ctrl_bench;
  import dccx_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic CLK_SYS, RESET, SVC_CMD_OUT, SVC_ACK_WAIT, SVC_REQ_IN, SVC_REQ_NEEDS, SVC_CMD_WANT;
  logic RSP_IN, ARRIVED, LATE_RNG, REQ_SEND, REJ_TEMP_DCC, REJ_TEMP, SVC_CMD_GO, BUSY, FAIL;
  logic OLD_HOLD, NEW_HOLD, RNG_ABORT, REINIT_BLOCKED, slow, ask, ask_needs, retried;
  logic [MS_W-1:0] T15_MS, jump_ms;
  dccx_cfg_t CFG;
  dccx_cmd_t CMD;
  int fail_count, n_checks, cycles, n_req, n_rtd, n_rt, n_blk, n_go, n_gobad, n_fail;

  dccx_ctrl dccx_ctrl_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .CFG(CFG), .CMD(CMD),
    .SVC_CMD_OUT(SVC_CMD_OUT), .SVC_ACK_WAIT(SVC_ACK_WAIT), .SVC_REQ_IN(SVC_REQ_IN),
    .SVC_REQ_NEEDS(SVC_REQ_NEEDS), .SVC_CMD_WANT(SVC_CMD_WANT), .RSP_IN(RSP_IN), .ARRIVED(ARRIVED),
    .LATE_RNG(LATE_RNG), .REQ_SEND(REQ_SEND), .REJ_TEMP_DCC(REJ_TEMP_DCC), .REJ_TEMP(REJ_TEMP),
    .SVC_CMD_GO(SVC_CMD_GO), .BUSY(BUSY), .FAIL(FAIL), .OLD_HOLD(OLD_HOLD), .NEW_HOLD(NEW_HOLD),
    .RNG_ABORT(RNG_ABORT), .REINIT_BLOCKED(REINIT_BLOCKED), .T15_MS(T15_MS));

  dccx_modem_model dccx_modem_model_inst (.clk_sys(CLK_SYS), .reset(RESET), .req_send(REQ_SEND),
    .rej_temp_dcc(REJ_TEMP_DCC), .rej_temp(REJ_TEMP), .slow(slow), .ask(ask), .ask_needs(ask_needs),
    .rsp_in(RSP_IN), .arrived(ARRIVED), .svc_req_in(SVC_REQ_IN), .svc_req_needs(SVC_REQ_NEEDS),
    .jump_ms(jump_ms), .retried(retried));

  // ----------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // Pulses last one cycle, so they are counted at every edge rather than polled
  always @(posedge CLK_SYS) begin
    cycles   <= cycles + 1;
    n_req    <= n_req + (REQ_SEND === 1'b1);
    n_rtd    <= n_rtd + (REJ_TEMP_DCC === 1'b1);
    n_rt     <= n_rt + (REJ_TEMP === 1'b1);
    n_blk    <= n_blk + (REINIT_BLOCKED === 1'b1);
    n_go     <= n_go + (SVC_CMD_GO === 1'b1);
    n_gobad  <= n_gobad + (SVC_CMD_GO === 1'b1 && BUSY === 1'b1);
    n_fail   <= n_fail + (FAIL === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Expected reservation time, worked out from the current settings
  function automatic int calc_t15(dccx_tech_t tech, logic jv, logic [16:0] jms);
    int j, a, rng, t;
    j   = jv ? int'(jms) : JUMP_DEFAULT_MS;
    a   = int'(CFG.rng_allow);
    a   = (a < RNG_ALLOW_MIN_MS) ? RNG_ALLOW_MIN_MS : (a > RNG_ALLOW_MAX_MS) ? RNG_ALLOW_MAX_MS : a;
    rng = (tech == DCCX_TECH_INIT_MAINT || tech == DCCX_TECH_EITHER) ? INIT_MAINT_RNG_MS
          : 2 * int'(CFG.rng_opp_period) + a;
    t   = j + 2 * int'(CFG.ucd_period) + 2 * int'(CFG.sync_period) + rng;
    return (t < T15_MIN_MS) ? T15_MIN_MS : (t > T15_MAX_MS) ? T15_MAX_MS : t;
  endfunction

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (BUSY !== lvl && k < 300) begin
      step(1);
      k++;
    end
    check(BUSY, lvl, "busy level not reached");
  endtask

  // One full change: request, reply, arrival, then both holds released
  task automatic run_change(input dccx_tech_t tech, input logic jv, input logic [16:0] jms);
    n_req = 0;
    CMD   = '{valid: 1'b1, tech: tech, jump_valid: jv, jump_ms: jms};
    wait_busy(1'b1);
    CMD.valid = 1'b0;
    while (REQ_SEND !== 1'b1 && n_req == 0 && cycles < 19000) step(1);
    check(T15_MS, calc_t15(tech, jv, jms), "reservation time");
    step(1);
    check({OLD_HOLD, NEW_HOLD}, 2'h3, "holds after request");
    wait_busy(1'b0);
    check(n_req, 1, "request count");
    check({OLD_HOLD, NEW_HOLD}, 2'h0, "holds after arrival");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_t15();
    run_change(DCCX_TECH_DIRECT, 1'b1, jump_ms);
    run_change(DCCX_TECH_DIRECT, 1'b0, 17'h0);
    run_change(DCCX_TECH_STA_MAINT, 1'b1, 17'h320);
    run_change(DCCX_TECH_INIT_MAINT, 1'b1, 17'h3e8);
    // Late ranging while the reservation still runs must not abort
    LATE_RNG = 1'b1;
    step(1);
    LATE_RNG = 1'b0;
    check(RNG_ABORT, 1'b0, "abort while reserved");
    run_change(DCCX_TECH_EITHER, 1'b1, 17'h1388);
    CFG.rng_allow = 17'ha;
    run_change(DCCX_TECH_DIRECT, 1'b1, 17'h5dc);
    CFG.rng_allow = 17'h1e;
  endtask

  task automatic t_reinit();
    CFG.prov_fixes_chan = 1'b1;
    n_blk = 0;
    n_req = 0;
    CMD   = '{valid: 1'b1, tech: DCCX_TECH_REINIT, jump_valid: 1'b0, jump_ms: 17'h0};
    step(4);
    CMD.valid = 1'b0;
    step(6);
    check(n_blk != 0, 1, "reinit not refused");
    check({n_req != 0, BUSY}, 2'h0, "refused change started");
    CFG.prov_fixes_chan = 1'b0;
  endtask

  task automatic t_svc_block();
    for (int i = 0; i < 2; i++) begin
      SVC_CMD_OUT  = (i == 0);
      SVC_ACK_WAIT = (i == 1);
      n_req = 0;
      CMD   = '{valid: 1'b1, tech: DCCX_TECH_DIRECT, jump_valid: 1'b0, jump_ms: 17'h0};
      step(20);
      check({n_req != 0, BUSY}, 2'h0, "change while service pending");
      CMD.valid    = 1'b0;
      SVC_CMD_OUT  = 1'b0;
      SVC_ACK_WAIT = 1'b0;
      run_change(DCCX_TECH_DIRECT, 1'b0, 17'h0);
    end
  endtask

  task automatic t_svc_go();
    n_gobad      = 0;
    n_go         = 0;
    SVC_CMD_WANT = 1'b1;
    run_change(DCCX_TECH_STA_MAINT, 1'b0, 17'h0);
    check(n_gobad, 0, "service command while busy");
    step(10);
    check(n_go != 0, 1, "service command never granted");
    SVC_CMD_WANT = 1'b0;
    step(2);
  endtask

  task automatic t_reject();
    n_rtd     = 0;
    n_req     = 0;
    ask       = 1'b1;
    ask_needs = 1'b1;
    step(1);
    ask = 1'b0;
    while (n_rtd == 0 && cycles < 19000) step(1);
    check(n_req, 0, "change before reject");
    wait_busy(1'b1);
    while (n_req == 0 && cycles < 19000) step(1);
    check(T15_MS, calc_t15(DCCX_TECH_DIRECT, CMD.jump_valid, CMD.jump_ms), "pending change time");
    wait_busy(1'b0);
    step(12);
    check(n_rtd, 1, "reject count");
    check(retried, 1'b1, "modem never retried");
  endtask

  task automatic t_cross();
    slow  = 1'b1;
    n_rt  = 0;
    n_rtd = 0;
    CMD   = '{valid: 1'b1, tech: DCCX_TECH_DIRECT, jump_valid: 1'b0, jump_ms: 17'h0};
    wait_busy(1'b1);
    CMD.valid = 1'b0;
    ask       = 1'b1;
    ask_needs = 1'b0;
    step(1);
    ask = 1'b0;
    step(5);
    check({n_rt != 0, n_rtd != 0}, 2'h2, "crossing request not refused");
    wait_busy(1'b0);
    slow = 1'b0;
    step(12);
  endtask

  // Slow modem with no response wait: one resend, then a failure pulse
  task automatic t_retry();
    CFG.t11 = 17'h0;
    slow    = 1'b1;
    n_req   = 0;
    n_fail  = 0;
    CMD     = '{valid: 1'b1, tech: DCCX_TECH_DIRECT, jump_valid: 1'b0, jump_ms: 17'h0};
    wait_busy(1'b1);
    CMD.valid = 1'b0;
    wait_busy(1'b0);
    check(n_req, 2, "request resend count");
    check(n_fail, 1, "failure pulse count");
    // Let the late modem answers drain before anything else starts
    step(90);
    CFG.t11 = 17'h1;
    slow    = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RESET, SVC_CMD_OUT, SVC_ACK_WAIT, SVC_CMD_WANT, LATE_RNG, slow, ask, ask_needs} = 8'h80;
    {fail_count, n_checks, cycles} = '0;
    CFG = '{ucd_period: 17'h1f4, sync_period: 17'h32, rng_opp_period: 17'h14, rng_allow: 17'h1e,
            t11: 17'h1, req_retries: 4'h1, prov_fixes_chan: 1'b0};
    CMD = '0;
    repeat (3) @(posedge CLK_SYS);
    #1;
    RESET = 1'b0;
    check({BUSY, OLD_HOLD, NEW_HOLD, T15_MS}, 32'h0, "outputs after reset");
    t_t15();
    t_reinit();
    t_svc_block();
    t_svc_go();
    t_reject();
    t_cross();
    t_retry();
    end_of_test();
  end

endmodule // channel_change_transaction_ctrl_bench
